/* File: src/hspc_pkg.sv */
package hspc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int IRQ_MIN_NS        = 8000;
    // least time: round up to whole cycles
    localparam int IRQ_CYC           = (IRQ_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int IRQ_CNT_W         = 8;
    localparam logic [IRQ_CNT_W-1:0] IRQ_LOAD = IRQ_CNT_W'(IRQ_CYC);

    localparam int WDT_TIMEOUT_US    = 100000;
    localparam int WDT_CYC_DEF       = (WDT_TIMEOUT_US * 1000) / SYS_CLK_PERIOD_NS;
    localparam int WDT_CNT_W         = 21;

    // ------------------------------------------------------------------
    // buffers and serial framing
    // ------------------------------------------------------------------
    localparam int BYTE_W            = 8;
    localparam int TX_DEPTH          = 33;
    localparam int RX_DEPTH          = 40;
    localparam int BIT_CNT_W         = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam int RD_DIR_BIT        = 7;

    // ------------------------------------------------------------------
    // synchronised pin vector layout and idle values
    // ------------------------------------------------------------------
    localparam int PIN_SCK           = 0;
    localparam int PIN_CS_N          = 1;
    localparam int PIN_CMD           = 2;
    localparam int PIN_WIRE3         = 3;
    localparam int PIN_SDI           = 4;
    localparam int N_PINS            = 5;
    localparam logic [N_PINS-1:0] PIN_RST = 5'h1b;

endpackage

/* File: src/hspc_fifo.sv */
`timescale 1ns/1ps
module hspc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // clock and clear
    input  wire logic         i_clk,
    input  wire logic         i_clr,
    // fill side
    input  wire logic         i_wr_valid,
    input  wire logic [W-1:0] i_wr_data,
    output logic              o_wr_ready,
    // drain side
    output logic              o_rd_valid,
    output logic [W-1:0]      o_rd_data,
    input  wire logic         i_rd_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] P_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] C_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } hspc_fifo_s;

    hspc_fifo_s s_q;
    hspc_fifo_s s_d;
    logic       push;
    logic       pop;

    assign o_wr_ready = (s_q.cnt != C_FULL);
    assign o_rd_valid = (s_q.cnt != '0);
    assign o_rd_data  = s_q.mem[s_q.rp];

    always_comb begin
        s_d  = s_q;
        push = i_wr_valid && o_wr_ready;
        pop  = i_rd_ready && o_rd_valid;
        if (push) begin
            s_d.mem[s_q.wp] = i_wr_data;
            s_d.wp = (s_q.wp == P_LAST) ? '0 : PW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = (s_q.rp == P_LAST) ? '0 : PW'(s_q.rp + 1'b1);
        end
        if (push && !pop) begin
            s_d.cnt = CW'(s_q.cnt + 1'b1);
        end else if (pop && !push) begin
            s_d.cnt = CW'(s_q.cnt - 1'b1);
        end
        if (i_clr) begin
            s_d = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        s_q <= s_d;
    end

endmodule

/* File: src/hspc_host_serial_port.sv */
`timescale 1ns/1ps
// Functional notes
// [RULE1] wire-count select high gives three-wire mode, low gives two-wire mode
// [RULE2] serial input is input-only in three-wire; shared data line in two-wire
// [RULE3] serial output drives only in three-wire mode; released after any reset
// [RULE4] chip select low enables shift clocks and serial exchange
// [RULE5] chip select high floats serial output and clears the bit counter
// [RULE6] command/data select high: register address then data reads and writes
// [RULE7] every level change of command/data select clears the bit counter
// [RULE8] return code or crash raises interrupt for at least 8 us
// [RULE9] interrupt output low after hardware and software reset
// [RULE10] bytes shift most significant bit first both ways
// [RULE11] host-written bytes queue in a 33-byte first-in first-out buffer
// [RULE12] received bytes queue in a 40-byte buffer until the host reads
// [RULE13] watchdog timer detects host crash and reports it as interrupt
// [RULE14] hardware reset stops oscillator; software reset keeps it running
// [RULE15] host supplies the shift clock; device only receives it
// [RULE16] differential bus lines released after either reset
// [RULE17] logic timed from one system clock
// [RULE18] low reset input resets; held low at power-up, high otherwise
// [RULE19] output bit changes on falling shift edge, input sampled on rising
module hspc_host_serial_port
    import hspc_pkg::*;
#(
    parameter int unsigned P_WDT_CYC = hspc_pkg::WDT_CYC_DEF
) (
    // clock and resets
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_soft_rst,
    // host serial pins
    input  wire logic                      i_sck,
    input  wire logic                      i_cs_n,
    input  wire logic                      i_cmd_sel,
    input  wire logic                      i_wire3_sel,
    input  wire logic                      i_serial_in,
    output logic                           o_sdo,
    output logic                           o_sdo_oe,
    output logic                           o_shared_serial_line,
    output logic                           o_shared_serial_line_oe,
    output logic                           o_irq,
    // resonator and bus pins
    output logic                           o_osc_en,
    input  wire logic                      i_bus_drive,
    input  wire logic                      i_bus_level,
    output logic                           o_bus_oe,
    output logic                           o_bus_level,
    // protocol core side
    output logic [hspc_pkg::BYTE_W-1:0]    o_cmd_byte,
    output logic                           o_cmd_valid,
    output logic [hspc_pkg::BYTE_W-1:0]    o_reg_addr,
    output logic [hspc_pkg::BYTE_W-1:0]    o_tx_data,
    output logic                           o_tx_valid,
    input  wire logic                      i_tx_ready,
    input  wire logic [hspc_pkg::BYTE_W-1:0] i_rx_data,
    input  wire logic                      i_rx_valid,
    output logic                           o_rx_ready,
    input  wire logic                      i_ret_code_evt,
    input  wire logic                      i_wdt_en
);
    import hspc_pkg::*;

    localparam logic [WDT_CNT_W-1:0] WDT_LAST = WDT_CNT_W'(P_WDT_CYC - 1);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [N_PINS-1:0]    sync1;
        logic [N_PINS-1:0]    sync2;
        logic [N_PINS-1:0]    sync3;
        logic [N_PINS-1:0]    pins;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [BYTE_W-1:0]    in_sh;
        logic [BYTE_W-1:0]    out_sh;
        logic                 out_from_fifo;
        logic                 addr_done;
        logic [BYTE_W-1:0]    reg_addr;
        logic [BYTE_W-1:0]    cmd_byte;
        logic                 cmd_valid;
        logic                 tx_wr_valid;
        logic [BYTE_W-1:0]    tx_wr_data;
        logic                 sdo;
        logic                 sdo_oe;
        logic                 sio_out;
        logic                 sio_oe;
        logic [IRQ_CNT_W-1:0] irq_cnt;
        logic                 irq;
        logic [WDT_CNT_W-1:0] wdt_cnt;
        logic                 osc_en;
        logic                 bus_oe;
        logic                 bus_level;
    } hspc_port_s;

    hspc_port_s        s_q;
    hspc_port_s        s_d;
    logic [N_PINS-1:0] pin_raw;
    logic              rst;
    logic              sck_rise;
    logic              sck_fall;
    logic              cs_act;
    logic              cmd_chg;
    logic              byte_done;
    logic              kick;
    logic              wdt_expire;
    logic              rx_pop;
    logic              read_phase;
    logic [BYTE_W-1:0] in_next;
    logic              tx_wr_ready;
    logic              rx_head_valid;
    logic [BYTE_W-1:0] rx_head;

    assign pin_raw = {i_serial_in, i_wire3_sel, i_cmd_sel, i_cs_n, i_sck};
    assign rst     = !i_rst_n || i_soft_rst;

    // ------------------------------------------------------------------
    // buffers
    // ------------------------------------------------------------------
    // a full transmit buffer drops the byte: the host has no wait line
    hspc_fifo #(.W(BYTE_W), .DEPTH(TX_DEPTH)) u_tx_fifo ( // [RULE11]
        .i_clk      (i_sys_clk),
        .i_clr      (rst),
        .i_wr_valid (s_q.tx_wr_valid),
        .i_wr_data  (s_q.tx_wr_data),
        .o_wr_ready (tx_wr_ready),
        .o_rd_valid (o_tx_valid),
        .o_rd_data  (o_tx_data),
        .i_rd_ready (i_tx_ready)
    );

    hspc_fifo #(.W(BYTE_W), .DEPTH(RX_DEPTH)) u_rx_fifo ( // [RULE12]
        .i_clk      (i_sys_clk),
        .i_clr      (rst),
        .i_wr_valid (i_rx_valid),
        .i_wr_data  (i_rx_data),
        .o_wr_ready (o_rx_ready),
        .o_rd_valid (rx_head_valid),
        .o_rd_data  (rx_head),
        .i_rd_ready (rx_pop)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = pin_raw;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        // a pin level counts once the second and third stages agree
        for (int i = 0; i < N_PINS; i++) begin
            if (s_q.sync2[i] == s_q.sync3[i]) begin
                s_d.pins[i] = s_q.sync3[i];
            end
        end
        // shift clock comes only from the host pin [RULE15]
        sck_rise   = !s_q.pins[PIN_SCK] && s_d.pins[PIN_SCK];
        sck_fall   = s_q.pins[PIN_SCK] && !s_d.pins[PIN_SCK];
        cs_act     = !s_d.pins[PIN_CS_N]; // [RULE4]
        cmd_chg    = s_d.pins[PIN_CMD] != s_q.pins[PIN_CMD];
        in_next    = {s_q.in_sh[BYTE_W-2:0], s_d.pins[PIN_SDI]}; // [RULE10]
        byte_done  = 1'b0;
        rx_pop     = 1'b0;
        read_phase = s_d.pins[PIN_CMD] && s_q.addr_done && s_q.reg_addr[RD_DIR_BIT];
        s_d.cmd_valid   = 1'b0;
        s_d.tx_wr_valid = 1'b0;

        if (!cs_act || cmd_chg) begin
            s_d.bit_cnt       = '0; // [RULE5] [RULE7]
            s_d.addr_done     = 1'b0;
            s_d.out_from_fifo = 1'b0;
            s_d.out_sh        = '0;
        end else begin
            if (sck_rise) begin
                s_d.in_sh   = in_next; // [RULE19]
                s_d.bit_cnt = BIT_CNT_W'(s_q.bit_cnt + 1'b1);
                if (s_q.bit_cnt == BIT_LAST) begin
                    byte_done = 1'b1;
                    if (!s_d.pins[PIN_CMD]) begin
                        s_d.cmd_byte  = in_next;
                        s_d.cmd_valid = 1'b1;
                    end else if (!s_q.addr_done) begin
                        s_d.reg_addr  = in_next; // [RULE6]
                        s_d.addr_done = 1'b1;
                    end else if (!s_q.reg_addr[RD_DIR_BIT]) begin
                        s_d.tx_wr_data  = in_next; // [RULE6]
                        s_d.tx_wr_valid = 1'b1;
                    end
                    rx_pop            = s_q.out_from_fifo;
                    s_d.out_from_fifo = 1'b0;
                end
            end else if (sck_fall) begin
                // first falling edge of a byte presents its most significant bit
                if (s_q.bit_cnt == '0) begin
                    s_d.out_from_fifo = read_phase && rx_head_valid;
                    s_d.out_sh        = s_d.out_from_fifo ? rx_head : '0;
                end else begin
                    s_d.out_sh = {s_q.out_sh[BYTE_W-2:0], 1'b0}; // [RULE10] [RULE19]
                end
            end
        end

        // pin drivers follow the sampled wire-count select
        s_d.sdo     = s_d.out_sh[BYTE_W-1];
        s_d.sio_out = s_d.out_sh[BYTE_W-1];
        s_d.sdo_oe  = s_d.pins[PIN_WIRE3] && cs_act; // [RULE1] [RULE3]
        s_d.sio_oe  = !s_d.pins[PIN_WIRE3] && cs_act && !cmd_chg && read_phase; // [RULE2]

        // watchdog: any completed byte proves the host is alive
        kick       = byte_done;
        wdt_expire = 1'b0;
        if (!i_wdt_en || kick) begin
            s_d.wdt_cnt = '0;
        end else if (s_q.wdt_cnt == WDT_LAST) begin
            wdt_expire  = 1'b1; // [RULE13]
            s_d.wdt_cnt = '0;
        end else begin
            s_d.wdt_cnt = WDT_CNT_W'(s_q.wdt_cnt + 1'b1);
        end

        // a new event reloads the pulse even while it is still high
        if (i_ret_code_evt || wdt_expire) begin
            s_d.irq_cnt = IRQ_LOAD; // [RULE8]
        end else if (s_q.irq_cnt != '0) begin
            s_d.irq_cnt = IRQ_CNT_W'(s_q.irq_cnt - 1'b1);
        end
        s_d.irq = (s_d.irq_cnt != '0);

        s_d.osc_en    = 1'b1;
        s_d.bus_oe    = i_bus_drive;
        s_d.bus_level = i_bus_level;

        if (rst) begin
            s_d       = '0; // [RULE9] [RULE16] [RULE18]
            s_d.sync1 = PIN_RST;
            s_d.sync2 = PIN_RST;
            s_d.sync3 = PIN_RST;
            s_d.pins  = PIN_RST;
            s_d.osc_en = i_rst_n; // [RULE14]
        end
    end

    // single system clock domain [RULE17]
    always_ff @(posedge i_sys_clk) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_sdo                   = s_q.sdo;
    assign o_sdo_oe                = s_q.sdo_oe;
    assign o_shared_serial_line    = s_q.sio_out;
    assign o_shared_serial_line_oe = s_q.sio_oe;
    assign o_irq                   = s_q.irq;
    assign o_osc_en                = s_q.osc_en;
    assign o_bus_oe                = s_q.bus_oe;
    assign o_bus_level             = s_q.bus_level;
    assign o_cmd_byte              = s_q.cmd_byte;
    assign o_cmd_valid             = s_q.cmd_valid;
    assign o_reg_addr              = s_q.reg_addr;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [IRQ_CNT_W-1:0] irq_hi_cnt_q;
    always_ff @(posedge i_sys_clk) begin
        if (rst || !o_irq) begin
            irq_hi_cnt_q <= '0;
        end else if (irq_hi_cnt_q != '1) begin
            irq_hi_cnt_q <= IRQ_CNT_W'(irq_hi_cnt_q + 1'b1);
        end
    end

    sequence irq_cause_s;
        i_ret_code_evt || wdt_expire;
    endsequence

    sequence irq_raised_s;
        o_irq ##1 o_irq;
    endsequence

    property irq_follows_cause_p;
        @(posedge i_sys_clk) disable iff (rst)
        irq_cause_s |=> irq_raised_s;
    endproperty

    chk_irq_event_raise: assert property (irq_follows_cause_p) // [RULE8] [RULE13]
        else $error("interrupt not raised after event");

    chk_irq_min_width: assert property ( // [RULE8]
        @(posedge i_sys_clk) disable iff (rst)
        $fell(o_irq) |-> (irq_hi_cnt_q >= IRQ_LOAD))
        else $error("interrupt pulse shorter than minimum");

    chk_reset_quiet_pins: assert property ( // [RULE9] [RULE3] [RULE16]
        @(posedge i_sys_clk)
        rst |=> !o_irq && !o_sdo_oe && !o_shared_serial_line_oe && !o_bus_oe)
        else $error("outputs not released after reset");

    chk_hw_osc_stop: assert property ( // [RULE14]
        @(posedge i_sys_clk)
        !i_rst_n |=> !o_osc_en)
        else $error("oscillator running during hardware reset");

    chk_soft_osc_run: assert property ( // [RULE14]
        @(posedge i_sys_clk)
        (i_rst_n && o_osc_en) ##1 (i_rst_n && i_soft_rst) |=> o_osc_en)
        else $error("soft reset stopped oscillator");

    chk_cs_high_idle: assert property ( // [RULE5] [RULE4]
        @(posedge i_sys_clk) disable iff (rst)
        s_q.pins[PIN_CS_N] |-> !o_sdo_oe && !o_shared_serial_line_oe && (s_q.bit_cnt == '0))
        else $error("port active with chip select high");

    chk_cmd_edge_clear: assert property ( // [RULE7]
        @(posedge i_sys_clk) disable iff (rst)
        $changed(s_q.pins[PIN_CMD]) |-> (s_q.bit_cnt == '0) && !s_q.addr_done)
        else $error("bit counter kept across select change");

    chk_wire_mode_drive: assert property ( // [RULE1] [RULE2] [RULE3]
        @(posedge i_sys_clk) disable iff (rst)
        (o_sdo_oe |-> s_q.pins[PIN_WIRE3]) and (o_shared_serial_line_oe |-> !s_q.pins[PIN_WIRE3]))
        else $error("serial line driven in wrong wire mode");

    chk_msb_first_out: assert property ( // [RULE10] [RULE19]
        @(posedge i_sys_clk) disable iff (rst)
        (sck_fall && cs_act && !cmd_chg && (s_q.bit_cnt != '0))
            |=> (o_sdo == $past(s_q.out_sh[BYTE_W-2])))
        else $error("output bit order wrong");

    chk_msb_first_in: assert property ( // [RULE10] [RULE6]
        @(posedge i_sys_clk) disable iff (rst)
        (byte_done && s_q.addr_done && s_d.pins[PIN_CMD] && !s_q.reg_addr[RD_DIR_BIT])
            |=> s_q.tx_wr_valid && (s_q.tx_wr_data[BYTE_W-1] == $past(s_q.in_sh[BYTE_W-2])))
        else $error("input byte not assembled msb first");

    chk_rx_pop_source: assert property ( // [RULE12]
        @(posedge i_sys_clk) disable iff (rst)
        rx_pop |-> rx_head_valid && s_q.out_from_fifo)
        else $error("receive buffer popped without a read byte");

endmodule

/* File: tb/hspc_host_model.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------
// host serial master: makes the shift clock, selects and frames
// --------------------------------------------------------------
module hspc_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_wire3,
    input  wire logic       i_sdo,
    input  wire logic       i_sdo_oe,
    input  wire logic       i_sio_val,
    input  wire logic       i_sio_oe,
    output logic            o_sck,
    output logic            o_cs_n,
    output logic            o_cmd_sel,
    output logic            o_serial_in,
    output logic [7:0]      o_rd_byte,
    output logic            o_rd_stb
);
    localparam int HALF = 10;
    logic host_oe  = 1'b1;
    logic host_bit = 1'b1;
    logic rd_line;

    // shared line rests high on its pull-up; a floated three-wire output reads as z,
    // so a missing enable shows up as a mismatch
    assign o_serial_in = i_wire3 ? host_bit
        : (i_sio_oe ? i_sio_val : (host_oe ? host_bit : 1'b1));
    assign rd_line     = i_wire3 ? (i_sdo_oe ? i_sdo : 1'bz) : o_serial_in;

    initial begin
        o_sck     = 1'b1;
        o_cs_n    = 1'b1;
        o_cmd_sel = 1'b0;
        o_rd_byte = 8'h00;
        o_rd_stb  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic select(input logic cmd);
        o_cmd_sel = cmd;
        o_cs_n    = 1'b0;
        tick(6);
    endtask

    task automatic set_cmd(input logic cmd);
        o_cmd_sel = cmd;
        tick(6);
    endtask

    task automatic deselect();
        o_cs_n   = 1'b1;
        host_bit = ~host_bit;
        tick(6);
    endtask

    // bits change on the falling edge and are read just before the rising edge
    task automatic shift(input logic [7:0] tx, input int nbits, input logic drv, input logic rd);
        logic [7:0] rx;
        rx      = 8'h00;
        host_oe = drv;
        for (int i = 7; i >= 8 - nbits; i--) begin
            o_sck    = 1'b0;
            host_bit = tx[i];
            tick(HALF);
            rx    = {rx[6:0], rd_line};
            o_sck = 1'b1;
            tick(HALF);
        end
        host_oe = 1'b1;
        if (rd) begin
            o_rd_byte = rx;
            o_rd_stb  = 1'b1;
            tick(1);
            o_rd_stb  = 1'b0;
        end
    endtask
endmodule

/* File: tb/host_serial_port_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", name, exp, got); end end
module host_serial_port_ctrl_tb;
    import hspc_pkg::*;
    localparam int WDT = 200;
    logic       sys_clk, rst_n, soft_rst, sck, cs_n, cmd_sel, wire3_sel, serial_in;
    logic       sdo, sdo_oe, shared_serial_line, sio_oe, irq, osc_en, bus_drive, bus_level, bus_oe, bus_out;
    logic [7:0] cmd_byte, reg_addr, tx_data, rx_data, rd_byte, b;
    logic       cmd_valid, tx_valid, tx_ready, rx_valid, rx_ready, ret_evt, wdt_en, rd_stb;
    int         fail_count = 0;
    int         check_count = 0;
    int         n;
    logic [7:0] exp_q[$];

    hspc_host_serial_port #(.P_WDT_CYC(WDT)) hspc_host_serial_port_inst (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_soft_rst(soft_rst), .i_sck(sck),
        .i_cs_n(cs_n), .i_cmd_sel(cmd_sel), .i_wire3_sel(wire3_sel), .i_serial_in(serial_in),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_shared_serial_line(shared_serial_line),
        .o_shared_serial_line_oe(sio_oe), .o_irq(irq), .o_osc_en(osc_en),
        .i_bus_drive(bus_drive), .i_bus_level(bus_level), .o_bus_oe(bus_oe),
        .o_bus_level(bus_out), .o_cmd_byte(cmd_byte), .o_cmd_valid(cmd_valid),
        .o_reg_addr(reg_addr), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
        .i_tx_ready(tx_ready), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
        .o_rx_ready(rx_ready), .i_ret_code_evt(ret_evt), .i_wdt_en(wdt_en));

    hspc_host_model hspc_host_model_inst (
        .i_clk(sys_clk), .i_wire3(wire3_sel), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .i_sio_val(shared_serial_line), .i_sio_oe(sio_oe), .o_sck(sck), .o_cs_n(cs_n),
        .o_cmd_sel(cmd_sel), .o_serial_in(serial_in), .o_rd_byte(rd_byte), .o_rd_stb(rd_stb));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic pop_cmp(input string name, input logic [7:0] got);
        logic [7:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
        `CHK(name, e, got)
    endtask

    task automatic conclude();
        $display("counts: checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // result watcher: each result takes the oldest expectation
    // --------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1) pop_cmp("cmd_byte", cmd_byte);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) pop_cmp("tx_data", tx_data);
        if (rd_stb === 1'b1) pop_cmp("rd_byte", rd_byte);
    end

    initial begin
        #(60000 * 50);
        fail_count++;
        $display("ERROR run_time expected done seen timeout");
        conclude();
    end

    initial begin
        {soft_rst, bus_drive, bus_level, rx_valid, ret_evt, wdt_en} = '0;
        {rst_n, rx_data, wire3_sel, tx_ready} = {1'b0, 8'h00, 1'b1, 1'b1};
        void'($urandom(32'hcf70));
        cyc(2);
        `CHK("osc_hw", 1'b0, osc_en)
        `CHK("irq_rst", 1'b0, irq)
        `CHK("sdo_oe_rst", 1'b0, sdo_oe)
        `CHK("bus_oe_rst", 1'b0, bus_oe)
        rst_n = 1'b1;
        cyc(2);
        `CHK("rx_ready_rst", 1'b1, rx_ready)
        `CHK("osc_run", 1'b1, osc_en)
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            hspc_host_model_inst.select(1'b0);
            hspc_host_model_inst.shift(b, 8, 1'b1, 1'b0);
            hspc_host_model_inst.deselect();
            `CHK("sdo_oe_cs_high", 1'b0, sdo_oe)
        end
        hspc_host_model_inst.select(1'b0);
        hspc_host_model_inst.shift(8'hff, 3, 1'b1, 1'b0);
        hspc_host_model_inst.deselect();
        b = 8'($urandom);
        exp_q.push_back(b);
        hspc_host_model_inst.select(1'b1);
        hspc_host_model_inst.shift(8'h00, 5, 1'b1, 1'b0);
        hspc_host_model_inst.set_cmd(1'b0);
        hspc_host_model_inst.shift(b, 8, 1'b1, 1'b0);
        hspc_host_model_inst.deselect();
        $display("test command bytes done");
        tx_ready = 1'b0;
        hspc_host_model_inst.select(1'b1);
        hspc_host_model_inst.shift(8'h05, 8, 1'b1, 1'b0);
        for (int k = 0; k < TX_DEPTH + 1; k++) begin
            b = 8'($urandom);
            if (k < TX_DEPTH) exp_q.push_back(b);
            hspc_host_model_inst.shift(b, 8, 1'b1, 1'b0);
        end
        hspc_host_model_inst.deselect();
        `CHK("reg_addr", 8'h05, reg_addr)
        // random back-pressure on the drain side exercises the pop handshake
        n = 0;
        while (tx_valid === 1'b1 && n < 400) begin
            tx_ready = 1'($urandom);
            n++;
            cyc(1);
        end
        tx_ready = 1'b1;
        cyc(2);
        `CHK("tx_overflow_dropped", 1'b0, tx_valid)
        $display("test transmit buffer done");
        for (int m = 0; m < 2; m++) begin
            n = (m == 0) ? RX_DEPTH : 4;
            wire3_sel = (m == 0);
            cyc(6);
            // gaps in the fill stream come from a random valid
            for (int k = 0; k < n; k += int'(rx_valid)) begin
                rx_valid = 1'($urandom);
                rx_data  = 8'($urandom);
                if (rx_valid) exp_q.push_back(rx_data);
                cyc(1);
            end
            rx_valid = 1'b0;
            cyc(1);
            if (m == 0) `CHK("rx_full", 1'b0, rx_ready)
            if (m == 0) exp_q.push_back(8'h00);
            hspc_host_model_inst.select(1'b1);
            hspc_host_model_inst.shift(8'h80, 8, 1'b1, 1'b0);
            for (int k = 0; k < n + (m == 0); k++) begin
                hspc_host_model_inst.shift(8'h00, 8, 1'b0, 1'b1);
            end
            if (m == 1) `CHK("sdo_oe_two_wire", 1'b0, sdo_oe)
            hspc_host_model_inst.deselect();
            `CHK("sio_oe_cs_high", 1'b0, sio_oe)
        end
        wire3_sel = 1'b1;
        $display("test receive buffer done");
        {bus_drive, bus_level} = 2'($urandom);
        ret_evt = 1'b1;
        cyc(1);
        ret_evt = 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 5) begin
            n++;
            cyc(1);
        end
        n = 0;
        while (irq === 1'b1 && n < 400) begin
            n++;
            cyc(1);
        end
        `CHK("irq_len", IRQ_CYC, n)
        `CHK("bus_oe", bus_drive, bus_oe)
        `CHK("bus_level", bus_level, bus_out)
        bus_drive = 1'b1;
        ret_evt = 1'b1;
        cyc(1);
        ret_evt = 1'b0;
        cyc(3);
        `CHK("irq_retrig", 1'b1, irq)
        `CHK("bus_oe_on", 1'b1, bus_oe)
        soft_rst = 1'b1;
        cyc(2);
        `CHK("irq_soft", 1'b0, irq)
        `CHK("bus_oe_soft", 1'b0, bus_oe)
        `CHK("osc_soft", 1'b1, osc_en)
        {soft_rst, bus_drive} = 2'b00;
        cyc(2);
        $display("test interrupt and soft reset done");
        wdt_en = 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            n++;
            cyc(1);
        end
        `CHK("wdt_fire", 1'b1, (n > WDT - 10 && n <= WDT + 5))
        wdt_en = 1'b0;
        cyc(200);
        $display("test watchdog done");
        `CHK("results_left", 0, exp_q.size())
        conclude();
    end
endmodule
